// file: temp_readout_pkg.sv
// Register map, field positions, reset values and channel codes for the result readout
package temp_readout_pkg;
  localparam int RES_W = 10;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int AVG_LOG2 = 4;

  localparam logic [ADDR_W-1:0] ADDR_LIMIT_FLAGS_FIRST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_FLAGS_SECOND = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_INT_SUP_LOW_BITS = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_EXT_LOW_BITS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SUPPLY_HIGH_BITS = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_INT_HIGH_BITS = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_EXT_HIGH_BITS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG_FIRST = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG_SECOND = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG_THIRD = 8'h1A;
  localparam logic [ADDR_W-1:0] ADDR_MASK_FIRST = 8'h1D;
  localparam logic [ADDR_W-1:0] ADDR_MASK_SECOND = 8'h1E;
  localparam logic [ADDR_W-1:0] ADDR_INT_OFFSET = 8'h1F;
  localparam logic [ADDR_W-1:0] ADDR_EXT_OFFSET = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_SUPPLY_BOUND = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_SUPPLY_BOUND = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_INT_UPPER_TEMP_BOUND = 8'h25;
  localparam logic [ADDR_W-1:0] ADDR_INT_LOWER_TEMP_BOUND = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_EXT_UPPER_TEMP_BOUND = 8'h27;
  localparam logic [ADDR_W-1:0] ADDR_EXT_LOWER_TEMP_BOUND = 8'h28;

  localparam logic [REG_W-1:0] RST_UPPER_SUPPLY_BOUND = 8'hC7;
  localparam logic [REG_W-1:0] RST_LOWER_SUPPLY_BOUND = 8'h62;
  localparam logic [REG_W-1:0] RST_INT_UPPER_TEMP_BOUND = 8'h64;
  localparam logic [REG_W-1:0] RST_INT_LOWER_TEMP_BOUND = 8'hC9;
  localparam logic [REG_W-1:0] RST_EXT_UPPER_TEMP_BOUND = 8'hFF;
  localparam logic [REG_W-1:0] RST_EXT_LOWER_TEMP_BOUND = 8'h00;

  // Configuration fields
  localparam int CFG1_MONITOR_EN_BIT = 0;
  localparam int CFG1_ALERT_ACTIVE_HIGH_BIT = 6;
  localparam int CFG1_SOFT_RESET_BIT = 7;
  localparam int CFG2_AVG_DISABLE_BIT = 5;

  // First flag register fields
  localparam int FLAG_INT_ABOVE_BIT = 0;
  localparam int FLAG_INT_BELOW_BIT = 1;
  localparam int FLAG_EXT_ABOVE_BIT = 2;
  localparam int FLAG_EXT_BELOW_BIT = 3;
  // Second flag register fields
  localparam int FLAG_SUP_ABOVE_BIT = 0;
  localparam int FLAG_SUP_BELOW_BIT = 1;

  // Low-bit register fields
  localparam int LOW_INT_POS = 0;
  localparam int LOW_SUP_POS = 2;
  localparam int LOW_EXT_POS = 0;

  localparam logic ALERT_IDLE = 1'b1;

  typedef enum logic [1:0] {
    CH_SUPPLY,
    CH_INT,
    CH_EXT,
    CH_NONE
  } channel_t;
endpackage : temp_readout_pkg

// file: limit_compare.sv
// Window comparison of a 10-bit result's upper eight bits against 8-bit limits
`timescale 1ns/10ps
module limit_compare #(
  parameter bit SIGNED_CMP = 1'b1
) (
  input wire logic [temp_readout_pkg::RES_W-1:0] result,
  input wire logic [temp_readout_pkg::REG_W-1:0] high_limit,
  input wire logic [temp_readout_pkg::REG_W-1:0] low_limit,
  output logic above,
  output logic at_or_below
);
  import temp_readout_pkg::*;

  logic [REG_W-1:0] top;

  always_comb begin
    top = result[RES_W-1:RES_W-REG_W];
    if (SIGNED_CMP) begin
      above = $signed(top) > $signed(high_limit);
      at_or_below = $signed(top) <= $signed(low_limit);
    end else begin
      above = top > high_limit;
      at_or_below = top <= low_limit;
    end
  end
endmodule : limit_compare

// file: result_averager.sv
// Block average over a power-of-two number of signed results, with bypass
`timescale 1ns/10ps
module result_averager #(
  parameter int LOG2_SAMPLES = temp_readout_pkg::AVG_LOG2
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic bypass,
  input wire logic in_valid,
  input wire logic [temp_readout_pkg::RES_W-1:0] in_data,
  output logic out_valid,
  output logic [temp_readout_pkg::RES_W-1:0] out_data
);
  import temp_readout_pkg::*;

  localparam int SUM_W = RES_W + LOG2_SAMPLES;

  typedef struct packed {
    logic [SUM_W-1:0] sum;
    logic [LOG2_SAMPLES-1:0] count;
    logic valid;
    logic [RES_W-1:0] data;
  } avg_state_t;

  avg_state_t s_reg;
  avg_state_t s_next;
  logic [SUM_W-1:0] total;

  always_comb begin
    s_next = s_reg;
    total = s_reg.sum + {{LOG2_SAMPLES{in_data[RES_W-1]}}, in_data};
    s_next.valid = 1'b0;
    if (clear) begin
      s_next.sum = '0;
      s_next.count = '0;
    end else if (in_valid && bypass) begin
      s_next.valid = 1'b1;
      s_next.data = in_data;
      s_next.sum = '0;
      s_next.count = '0;
    end else if (in_valid) begin
      if (&s_reg.count) begin
        s_next.valid = 1'b1;
        s_next.data = total[SUM_W-1:LOG2_SAMPLES];
        s_next.sum = '0;
        s_next.count = '0;
      end else begin
        s_next.sum = total;
        s_next.count = s_reg.count + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign out_valid = s_reg.valid;
  assign out_data = s_reg.data;
endmodule : result_averager

// file: temp_result_limit_readout.sv
// Result registers, offset, averaging, limit flags, alert and split-read lock-out
`timescale 1ns/10ps

// Summary of operation
// - Temperature results are 10-bit two's-complement codes.
// - Internal offset register is added to internal reading before storing.
// - External results are averaged over 16 measurements before storing.
// - One code step equals 0.25 degrees; span is 255.75 degrees.
// - Bit 9 is sign; zero is all zeros, minus quarter degree all ones.
// - Flag when result above high limit or at or below low limit.
// - Limits are 8 bits, compared against 10-bit results.
// - Unmasked out-of-limit comparisons set bits in flag registers 0x00, 0x01.
// - Any unmasked flag drives alert active at programmed polarity.
// - Registers are 8 bits each; 10-bit results split low and high.
// - Supply upper eight bits at 0x06, lower two bits at 0x03.
// - Reading a low-bit register first freezes its high-bit registers.
// - First read of 0x03 locks both 0x06 and 0x07.
// - Reading any locked high register unlocks all locked high registers.
// - Reading a high register first does not lock its low register.
// - No read locks another register of the same kind.
// - Config 0x19 bit 5 set disables averaging; enabled after reset.
// - Serial transfer stops and resets converter; restart when it ends.
// - First flag register clears on read if corrected, and on soft reset.
module temp_result_limit_readout (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic xfer_active,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [temp_readout_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [temp_readout_pkg::REG_W-1:0] reg_wdata,
  output logic [temp_readout_pkg::REG_W-1:0] reg_rdata,
  input wire logic conv_valid,
  input wire temp_readout_pkg::channel_t conv_chan,
  input wire logic [temp_readout_pkg::RES_W-1:0] conv_data,
  output logic adc_hold,
  output logic adc_restart,
  output logic alert_out
);
  import temp_readout_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0] cfg1;
    logic [REG_W-1:0] cfg2;
    logic [REG_W-1:0] cfg3;
    logic [REG_W-1:0] mask1;
    logic [REG_W-1:0] mask2;
    logic [REG_W-1:0] int_off;
    logic [REG_W-1:0] ext_off;
    logic [REG_W-1:0] upper_supply_bound;
    logic [REG_W-1:0] lower_supply_bound;
    logic [REG_W-1:0] int_upper_temp_bound;
    logic [REG_W-1:0] int_lower_temp_bound;
    logic [REG_W-1:0] ext_upper_temp_bound;
    logic [REG_W-1:0] ext_lower_temp_bound;
    logic [RES_W-1:0] sup_res;
    logic [RES_W-1:0] int_res;
    logic [RES_W-1:0] ext_res;
    logic [REG_W-1:0] sup_high;
    logic [REG_W-1:0] int_high;
    logic [REG_W-1:0] ext_high;
    logic lock_sup;
    logic lock_int;
    logic lock_ext;
    logic pend_sup;
    logic pend_int;
    logic pend_ext;
    logic [REG_W-1:0] flags1;
    logic [REG_W-1:0] flags2;
    logic [REG_W-1:0] cond1;
    logic [REG_W-1:0] cond2;
    logic [REG_W-1:0] rdata;
    logic hold;
    logic restart;
    logic alert;
  } readout_state_t;

  readout_state_t s_reg;
  readout_state_t s_next;

  logic accept;
  logic avg_valid;
  logic [RES_W-1:0] avg_data;
  logic sup_above;
  logic sup_below;
  logic int_above;
  logic int_below;
  logic ext_above;
  logic ext_below;
  logic [REG_W-1:0] ev1;
  logic [REG_W-1:0] ev2;
  logic [REG_W-1:0] clr1;
  logic [REG_W-1:0] clr2;
  logic active;

  // Offset is a signed count of quarter degrees; the sum wraps in 10 bits
  function automatic logic [RES_W-1:0] add_offset(input logic [RES_W-1:0] raw, input logic [REG_W-1:0] off);
    add_offset = raw + {{(RES_W-REG_W){off[REG_W-1]}}, off};
  endfunction : add_offset

  // Flag bits that survive the channel masks
  function automatic logic [REG_W-1:0] keep_unmasked(input logic [REG_W-1:0] bits, input logic [REG_W-1:0] mask);
    keep_unmasked = bits & ~mask;
  endfunction : keep_unmasked

  // Upper eight bits of a result, as held in the high-bit views
  function automatic logic [REG_W-1:0] high_bits(input logic [RES_W-1:0] res);
    high_bits = res[RES_W-1:RES_W-REG_W];
  endfunction : high_bits

  // Results arriving during a transfer are dropped while the converter is reset
  assign accept = conv_valid && !xfer_active && s_reg.cfg1[CFG1_MONITOR_EN_BIT];

  result_averager #(
    .LOG2_SAMPLES(AVG_LOG2)
  ) u_ext_avg (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(xfer_active || !s_reg.cfg1[CFG1_MONITOR_EN_BIT]),
    .bypass(s_reg.cfg2[CFG2_AVG_DISABLE_BIT]),
    .in_valid(accept && (conv_chan == CH_EXT)),
    .in_data(conv_data),
    .out_valid(avg_valid),
    .out_data(avg_data)
  );

  limit_compare #(
    .SIGNED_CMP(1'b0)
  ) u_sup_cmp (
    .result(s_reg.sup_res),
    .high_limit(s_reg.upper_supply_bound),
    .low_limit(s_reg.lower_supply_bound),
    .above(sup_above),
    .at_or_below(sup_below)
  );

  limit_compare #(
    .SIGNED_CMP(1'b1)
  ) u_int_cmp (
    .result(s_reg.int_res),
    .high_limit(s_reg.int_upper_temp_bound),
    .low_limit(s_reg.int_lower_temp_bound),
    .above(int_above),
    .at_or_below(int_below)
  );

  limit_compare #(
    .SIGNED_CMP(1'b1)
  ) u_ext_cmp (
    .result(s_reg.ext_res),
    .high_limit(s_reg.ext_upper_temp_bound),
    .low_limit(s_reg.ext_lower_temp_bound),
    .above(ext_above),
    .at_or_below(ext_below)
  );

  always_comb begin
    s_next = s_reg;
    ev1 = '0;
    ev2 = '0;
    clr1 = '0;
    clr2 = '0;
    active = 1'b0;

    // Converter is held in reset during a transfer and restarted as it ends
    s_next.hold = xfer_active;
    s_next.restart = s_reg.hold && !xfer_active;

    // New results; each triggers one comparison on the following cycle
    s_next.pend_sup = 1'b0;
    s_next.pend_int = 1'b0;
    s_next.pend_ext = 1'b0;
    if (accept && (conv_chan == CH_SUPPLY)) begin
      s_next.sup_res = conv_data;
      s_next.pend_sup = 1'b1;
    end
    if (accept && (conv_chan == CH_INT)) begin
      s_next.int_res = add_offset(conv_data, s_reg.int_off);
      s_next.pend_int = 1'b1;
    end
    if (avg_valid) begin
      s_next.ext_res = add_offset(avg_data, s_reg.ext_off);
      s_next.pend_ext = 1'b1;
    end

    // Comparison results; condition bits track the latest comparison
    if (s_reg.pend_int) begin
      ev1[FLAG_INT_ABOVE_BIT] = int_above;
      ev1[FLAG_INT_BELOW_BIT] = int_below;
      s_next.cond1[FLAG_INT_ABOVE_BIT] = int_above;
      s_next.cond1[FLAG_INT_BELOW_BIT] = int_below;
    end
    if (s_reg.pend_ext) begin
      ev1[FLAG_EXT_ABOVE_BIT] = ext_above;
      ev1[FLAG_EXT_BELOW_BIT] = ext_below;
      s_next.cond1[FLAG_EXT_ABOVE_BIT] = ext_above;
      s_next.cond1[FLAG_EXT_BELOW_BIT] = ext_below;
    end
    if (s_reg.pend_sup) begin
      ev2[FLAG_SUP_ABOVE_BIT] = sup_above;
      ev2[FLAG_SUP_BELOW_BIT] = sup_below;
      s_next.cond2[FLAG_SUP_ABOVE_BIT] = sup_above;
      s_next.cond2[FLAG_SUP_BELOW_BIT] = sup_below;
    end
    ev1 = keep_unmasked(ev1, s_reg.mask1);
    ev2 = keep_unmasked(ev2, s_reg.mask2);

    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        ADDR_LIMIT_FLAGS_FIRST: begin
          s_next.rdata = s_reg.flags1;
          clr1 = ~s_reg.cond1;
        end
        ADDR_LIMIT_FLAGS_SECOND: begin
          s_next.rdata = s_reg.flags2;
          clr2 = ~s_reg.cond2;
        end
        ADDR_INT_SUP_LOW_BITS: begin
          s_next.rdata = '0;
          s_next.rdata[LOW_INT_POS +: 2] = s_reg.int_res[1:0];
          s_next.rdata[LOW_SUP_POS +: 2] = s_reg.sup_res[1:0];
          // A low read freezes its group only while the group is free
          if (!s_reg.lock_sup && !s_reg.lock_int) begin
            s_next.lock_sup = 1'b1;
            s_next.lock_int = 1'b1;
          end
        end
        ADDR_EXT_LOW_BITS: begin
          s_next.rdata = '0;
          s_next.rdata[LOW_EXT_POS +: 2] = s_reg.ext_res[1:0];
          if (!s_reg.lock_ext) begin
            s_next.lock_ext = 1'b1;
          end
        end
        // A locked high view returns its frozen value and releases every lock
        ADDR_SUPPLY_HIGH_BITS: begin
          s_next.rdata = s_reg.sup_high;
          if (s_reg.lock_sup) begin
            s_next.lock_sup = 1'b0;
            s_next.lock_int = 1'b0;
            s_next.lock_ext = 1'b0;
          end
        end
        ADDR_INT_HIGH_BITS: begin
          s_next.rdata = s_reg.int_high;
          if (s_reg.lock_int) begin
            s_next.lock_sup = 1'b0;
            s_next.lock_int = 1'b0;
            s_next.lock_ext = 1'b0;
          end
        end
        ADDR_EXT_HIGH_BITS: begin
          s_next.rdata = s_reg.ext_high;
          if (s_reg.lock_ext) begin
            s_next.lock_sup = 1'b0;
            s_next.lock_int = 1'b0;
            s_next.lock_ext = 1'b0;
          end
        end
        ADDR_CONFIG_FIRST: s_next.rdata = s_reg.cfg1;
        ADDR_CONFIG_SECOND: s_next.rdata = s_reg.cfg2;
        ADDR_CONFIG_THIRD: s_next.rdata = s_reg.cfg3;
        ADDR_MASK_FIRST: s_next.rdata = s_reg.mask1;
        ADDR_MASK_SECOND: s_next.rdata = s_reg.mask2;
        ADDR_INT_OFFSET: s_next.rdata = s_reg.int_off;
        ADDR_EXT_OFFSET: s_next.rdata = s_reg.ext_off;
        ADDR_UPPER_SUPPLY_BOUND: s_next.rdata = s_reg.upper_supply_bound;
        ADDR_LOWER_SUPPLY_BOUND: s_next.rdata = s_reg.lower_supply_bound;
        ADDR_INT_UPPER_TEMP_BOUND: s_next.rdata = s_reg.int_upper_temp_bound;
        ADDR_INT_LOWER_TEMP_BOUND: s_next.rdata = s_reg.int_lower_temp_bound;
        ADDR_EXT_UPPER_TEMP_BOUND: s_next.rdata = s_reg.ext_upper_temp_bound;
        ADDR_EXT_LOWER_TEMP_BOUND: s_next.rdata = s_reg.ext_lower_temp_bound;
        default: s_next.rdata = '0;
      endcase
    end

    // Register writes; result and flag registers ignore writes
    if (reg_wr) begin
      case (reg_addr)
        // Soft reset bit is self-clearing and reads back as zero
        ADDR_CONFIG_FIRST: begin
          s_next.cfg1 = reg_wdata;
          s_next.cfg1[CFG1_SOFT_RESET_BIT] = 1'b0;
          if (reg_wdata[CFG1_SOFT_RESET_BIT]) begin
            clr1 = '1;
            clr2 = '1;
          end
        end
        ADDR_CONFIG_SECOND: s_next.cfg2 = reg_wdata;
        ADDR_CONFIG_THIRD: s_next.cfg3 = reg_wdata;
        ADDR_MASK_FIRST: s_next.mask1 = reg_wdata;
        ADDR_MASK_SECOND: s_next.mask2 = reg_wdata;
        ADDR_INT_OFFSET: s_next.int_off = reg_wdata;
        ADDR_EXT_OFFSET: s_next.ext_off = reg_wdata;
        ADDR_UPPER_SUPPLY_BOUND: s_next.upper_supply_bound = reg_wdata;
        ADDR_LOWER_SUPPLY_BOUND: s_next.lower_supply_bound = reg_wdata;
        ADDR_INT_UPPER_TEMP_BOUND: s_next.int_upper_temp_bound = reg_wdata;
        ADDR_INT_LOWER_TEMP_BOUND: s_next.int_lower_temp_bound = reg_wdata;
        ADDR_EXT_UPPER_TEMP_BOUND: s_next.ext_upper_temp_bound = reg_wdata;
        ADDR_EXT_LOWER_TEMP_BOUND: s_next.ext_lower_temp_bound = reg_wdata;
        default: begin
        end
      endcase
    end

    // A new event wins over a clear in the same cycle
    s_next.flags1 = (s_reg.flags1 & ~clr1) | ev1;
    s_next.flags2 = (s_reg.flags2 & ~clr2) | ev2;

    // High-bit views follow the results unless frozen
    s_next.sup_high = s_next.lock_sup ? s_reg.sup_high : high_bits(s_next.sup_res);
    s_next.int_high = s_next.lock_int ? s_reg.int_high : high_bits(s_next.int_res);
    s_next.ext_high = s_next.lock_ext ? s_reg.ext_high : high_bits(s_next.ext_res);

    active = |keep_unmasked(s_next.flags1, s_next.mask1) || |keep_unmasked(s_next.flags2, s_next.mask2);
    s_next.alert = s_next.cfg1[CFG1_ALERT_ACTIVE_HIGH_BIT] ? active : !active;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      // Limits start at their power-up values and the alert idles inactive
      s_reg <= '0;
      s_reg.upper_supply_bound <= RST_UPPER_SUPPLY_BOUND;
      s_reg.lower_supply_bound <= RST_LOWER_SUPPLY_BOUND;
      s_reg.int_upper_temp_bound <= RST_INT_UPPER_TEMP_BOUND;
      s_reg.int_lower_temp_bound <= RST_INT_LOWER_TEMP_BOUND;
      s_reg.ext_upper_temp_bound <= RST_EXT_UPPER_TEMP_BOUND;
      s_reg.ext_lower_temp_bound <= RST_EXT_LOWER_TEMP_BOUND;
      s_reg.alert <= ALERT_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign adc_hold = s_reg.hold;
  assign adc_restart = s_reg.restart;
  assign alert_out = s_reg.alert;
endmodule : temp_result_limit_readout

// file: temp_result_limit_readout_props.sv
// Port-level assertions for the result readout block
`timescale 1ns/10ps
module temp_result_limit_readout_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic xfer_active,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [temp_readout_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [temp_readout_pkg::REG_W-1:0] reg_wdata,
  input wire logic [temp_readout_pkg::REG_W-1:0] reg_rdata,
  input wire logic adc_hold,
  input wire logic adc_restart,
  input wire logic alert_out
);
  import temp_readout_pkg::*;
  logic soft_clr;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Soft reset with monitoring off, so no later result can raise a flag again
  assign soft_clr = reg_wr && reg_addr == ADDR_CONFIG_FIRST && reg_wdata[CFG1_SOFT_RESET_BIT]
    && !reg_wdata[CFG1_MONITOR_EN_BIT];

  property p_hold_on; xfer_active |=> adc_hold; endproperty
  a_hold_on: assert property (p_hold_on) else $error("hold missing in transfer");
  property p_hold_off; !xfer_active |=> !adc_hold; endproperty
  a_hold_off: assert property (p_hold_off) else $error("hold stuck after transfer");
  property p_restart; $fell(adc_hold) |-> adc_restart; endproperty
  a_restart: assert property (p_restart) else $error("restart pulse missing");
  property p_restart_cause; adc_restart |-> $fell(adc_hold); endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart without transfer end");
  property p_restart_once; adc_restart |=> !adc_restart; endproperty
  a_restart_once: assert property (p_restart_once) else $error("restart pulse too long");
  property p_rdata_hold; $changed(reg_rdata) |-> $past(reg_rd); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_low_pack; reg_rd && reg_addr == ADDR_INT_SUP_LOW_BITS |=> reg_rdata[7:4] == 4'h0; endproperty
  a_low_pack: assert property (p_low_pack) else $error("shared low register packing");
  property p_ext_pack; reg_rd && reg_addr == ADDR_EXT_LOW_BITS |=> reg_rdata[7:2] == 6'h00; endproperty
  a_ext_pack: assert property (p_ext_pack) else $error("external low register packing");
  property p_unmapped;
    reg_rd && (reg_addr == 8'h02 || reg_addr > ADDR_EXT_LOWER_TEMP_BOUND) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_clr_high; soft_clr && reg_wdata[CFG1_ALERT_ACTIVE_HIGH_BIT] |-> ##[1:4] !alert_out; endproperty
  a_clr_high: assert property (p_clr_high) else $error("alert active after clear");
  property p_clr_low; soft_clr && !reg_wdata[CFG1_ALERT_ACTIVE_HIGH_BIT] |-> ##[1:4] alert_out; endproperty
  a_clr_low: assert property (p_clr_low) else $error("alert low after clear");
endmodule : temp_result_limit_readout_props

// file: temp_host_model.sv
// Host model: register accesses, each framed as one serial transfer
`timescale 1ns/10ps
module temp_host_model (
  input wire logic sys_clk,
  output logic xfer_active,
  output logic reg_rd,
  output logic reg_wr,
  output logic [temp_readout_pkg::ADDR_W-1:0] reg_addr,
  output logic [temp_readout_pkg::REG_W-1:0] reg_wdata,
  input wire logic [temp_readout_pkg::REG_W-1:0] reg_rdata
);
  import temp_readout_pkg::*;
  initial begin
    xfer_active = 1'b0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic access(input logic rd, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
    output logic [REG_W-1:0] q);
    @(posedge sys_clk);
    #1;
    xfer_active = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = rd;
    reg_wr = !rd;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    // Released lines show the inverse so a stale value cannot pass
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
    @(posedge sys_clk);
    #1;
    xfer_active = 1'b0;
  endtask : access
endmodule : temp_host_model

// file: temp_result_limit_readout_bench.sv
// Self-checking bench for the result readout block
`timescale 1ns/10ps
module temp_result_limit_readout_bench;
  import temp_readout_pkg::*;
  logic sys_clk;
  logic resetn = 1'b0;
  logic xfer_active;
  logic reg_rd;
  logic reg_wr;
  logic [ADDR_W-1:0] reg_addr;
  logic [REG_W-1:0] reg_wdata;
  logic [REG_W-1:0] reg_rdata;
  logic conv_valid = 1'b0;
  channel_t conv_chan = CH_NONE;
  logic [RES_W-1:0] conv_data = 10'h000;
  logic adc_hold;
  logic adc_restart;
  logic alert_out;
  int bad_count = 0;
  int num_checks = 0;
  int i;
  logic [7:0] ra [10] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28};
  logic [7:0] re [10] = '{8'h00, 8'h00, 8'h00, 8'h00, RST_UPPER_SUPPLY_BOUND, RST_LOWER_SUPPLY_BOUND,
    RST_INT_UPPER_TEMP_BOUND, RST_INT_LOWER_TEMP_BOUND, RST_EXT_UPPER_TEMP_BOUND, RST_EXT_LOWER_TEMP_BOUND};

  temp_result_limit_readout DUT (.sys_clk(sys_clk), .resetn(resetn), .xfer_active(xfer_active),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data), .adc_hold(adc_hold),
    .adc_restart(adc_restart), .alert_out(alert_out));
  temp_host_model host (.sys_clk(sys_clk), .xfer_active(xfer_active), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.access(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.access(1'b1, a, 8'h00, q);
    check(q, exp);
  endtask : rd

  task automatic conv(input channel_t ch, input logic [RES_W-1:0] d);
    @(posedge sys_clk);
    #1;
    conv_valid = 1'b1;
    conv_chan = ch;
    conv_data = d;
    @(posedge sys_clk);
    #1;
    conv_valid = 1'b0;
    conv_chan = CH_NONE;
    conv_data = ~d;
    repeat (4) @(posedge sys_clk);
  endtask : conv

  task automatic alert_is(input logic exp);
    repeat (2) @(posedge sys_clk);
    #1;
    check({7'h00, alert_out}, {7'h00, exp});
  endtask : alert_is

  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    alert_is(ALERT_IDLE);
    for (i = 0; i < 10; i++) begin
      rd(ra[i], re[i]);
    end
    wr(8'h18, 8'h01);
    wr(8'h1F, 8'hFF);
    conv(CH_INT, 10'h000);
    rd(8'h03, 8'h03);
    rd(8'h07, 8'hFF);
    wr(8'h1F, 8'h04);
    conv(CH_INT, 10'h064);
    rd(8'h07, 8'h1A);
    wr(8'h1F, 8'h00);
    conv(CH_INT, 10'h193);
    rd(8'h00, 8'h00);
    conv(CH_INT, 10'h194);
    rd(8'h00, 8'h01);
    alert_is(1'b0);
    rd(8'h00, 8'h01);
    conv(CH_INT, 10'h000);
    rd(8'h00, 8'h01);
    rd(8'h00, 8'h00);
    alert_is(1'b1);
    conv(CH_INT, 10'h328);
    rd(8'h00, 8'h00);
    conv(CH_INT, 10'h327);
    rd(8'h00, 8'h02);
    conv(CH_INT, 10'h000);
    rd(8'h00, 8'h02);
    wr(8'h1D, 8'h01);
    conv(CH_INT, 10'h194);
    rd(8'h00, 8'h00);
    alert_is(1'b1);
    wr(8'h1D, 8'h00);
    conv(CH_INT, 10'h000);
    conv(CH_SUPPLY, 10'h2DB);
    rd(8'h06, 8'hB6);
    rd(8'h03, 8'h0C);
    conv(CH_SUPPLY, 10'h3FF);
    rd(8'h06, 8'hB6);
    rd(8'h06, 8'hFF);
    rd(8'h01, 8'h01);
    conv(CH_SUPPLY, 10'h188);
    rd(8'h01, 8'h03);
    rd(8'h01, 8'h02);
    wr(8'h18, 8'h41);
    alert_is(1'b1);
    wr(8'h18, 8'hC0);
    alert_is(1'b0);
    rd(8'h01, 8'h00);
    wr(8'h18, 8'h80);
    alert_is(1'b1);
    wr(8'h18, 8'h01);
    conv(CH_INT, 10'h0C8);
    conv(CH_SUPPLY, 10'h200);
    rd(8'h03, 8'h00);
    conv(CH_INT, 10'h12D);
    conv(CH_SUPPLY, 10'h249);
    rd(8'h07, 8'h32);
    rd(8'h06, 8'h92);
    rd(8'h07, 8'h4B);
    conv(CH_INT, 10'h192);
    rd(8'h03, 8'h06);
    conv(CH_INT, 10'h000);
    rd(8'h07, 8'h64);
    rd(8'h07, 8'h00);
    fork
      rd(8'h07, 8'h00);
      begin
        repeat (2) @(posedge sys_clk);
        conv(CH_INT, 10'h0C8);
      end
    join
    rd(8'h07, 8'h00);
    wr(8'h1D, 8'h0C);
    for (i = 0; i < 15; i++) begin
      conv(CH_EXT, i[0] ? 10'h104 : 10'h100);
    end
    rd(8'h08, 8'h00);
    for (i = 0; i < 16; i++) begin
      conv(CH_EXT, i[0] ? 10'h104 : 10'h100);
    end
    rd(8'h04, 8'h02);
    rd(8'h08, 8'h40);
    wr(8'h1D, 8'h00);
    wr(8'h19, 8'h20);
    rd(8'h03, 8'h04);
    conv(CH_EXT, 10'h3FC);
    rd(8'h08, 8'hFF);
    rd(8'h00, 8'h08);
    alert_is(1'b0);
    wrap_up();
  end
endmodule : temp_result_limit_readout_bench

bind temp_result_limit_readout temp_result_limit_readout_props chk (.sys_clk(sys_clk), .resetn(resetn),
  .xfer_active(xfer_active), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .adc_hold(adc_hold), .adc_restart(adc_restart), .alert_out(alert_out));
